// [design/ptmc_pkg.sv]
// Purpose: constants and types shared by the periodic timer mode control block
// Assumes: one 8-bit control register per channel, simple strobe register port
// Notes: offsets below are local register indices (byte addresses)
package ptmc_pkg;
	localparam int unsigned CNT_W = 16;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// register map
	localparam logic [3:0] OFS_CTRL0 = 4'h0;
	localparam logic [3:0] OFS_CTRL1 = 4'h1;
	localparam logic [3:0] OFS_CTRL2 = 4'h2;
	localparam logic [3:0] OFS_CTRL3 = 4'h3;
	localparam logic [3:0] OFS_RUN = 4'h4;
	localparam logic [3:0] OFS_CLRCOND = 4'h5;
	localparam logic [3:0] OFS_CNT_LO = 4'h6;
	localparam logic [3:0] OFS_CNT_HI = 4'h7;
	localparam logic [3:0] OFS_COMPARE_A_REGISTER_LO = 4'h8;
	localparam logic [3:0] OFS_COMPARE_A_REGISTER_HI = 4'h9;
	localparam logic [3:0] OFS_PERIOD_COMPARE_REGISTER_LO = 4'ha;
	localparam logic [3:0] OFS_PERIOD_COMPARE_REGISTER_HI = 4'hb;
	localparam logic [3:0] OFS_CAPTURE_B_REGISTER_LO = 4'hc;
	localparam logic [3:0] OFS_CAPTURE_B_REGISTER_HI = 4'hd;
	localparam logic [3:0] OFS_STATUS = 4'he;
	// capture source filter
	localparam int unsigned FILT_NS = 150;
	localparam int unsigned CLK_NS = 5;
	localparam int unsigned FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {
		PTMC_CMP = 2'h0,
		PTMC_CAP = 2'h1,
		PTMC_PWM = 2'h2,
		PTMC_TMR = 2'h3
	} ptmc_mode_e;
	typedef struct packed {
		ptmc_mode_e mode_sel;
		logic [1:0] pin_func;
		logic output_level_bit;
		logic output_polarity_bit;
		logic capture_source_sel;
		logic counter_clear_sel;
	} ptmc_ctrl_s;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ptmc_bus_s;
endpackage

// [design/ptmc_top.sv]
// Purpose: mode and pin-function control of a 4-channel periodic timer
// Assumes: register port with read data one cycle after the read strobe
// Notes: channel 0 alone has the second capture register and clear conditions
`timescale 1ns/100ps
module ptmc_top #(
	parameter int unsigned NCH = 4
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// register port
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// timer pins and sources
	input wire logic [NCH-1:0] tick_i,
	input wire logic [NCH-1:0] capture_input_pin_i,
	input wire logic [NCH-1:0] timer_clock_input_pin_i,
	input wire logic [NCH-1:0] noise_filter_out_i,
	input wire logic [NCH-1:0] noise_filter_input_select_i,
	output logic [NCH-1:0] timer_output_pin_o,
	output logic [NCH-1:0] timer_output_oe_o
);
	localparam int W = ptmc_pkg::CNT_W;
	ptmc_pkg::ptmc_bus_s bus;
	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	ptmc_pkg::ptmc_ctrl_s ctrl_q [NCH];
	logic [NCH-1:0] run_q;
	logic [1:0] clrcond_q;
	logic [W-1:0] cnt_q, compare_a_register_q, period_compare_register_q, capture_b_register_q;
	logic run0_prev_q;
	logic [NCH-1:0] src_prev_q;
	logic [NCH-1:0] pin_q;
	logic [NCH-1:0] pulse_done_q;
	logic [NCH-1:0] run_prev_q;
	logic [7:0] rdata_q;
	logic [5:0] filt_cnt_q [NCH];
	logic [NCH-1:0] filt_q;

	function automatic logic edge_hit(input logic [1:0] f, input logic rise, input logic fall);
		edge_hit = (f == 2'h0 && rise) || (f == 2'h1 && fall) || (f == 2'h2 && (rise || fall));
	endfunction

	wire wr_run = bus.wr && bus.addr == ptmc_pkg::OFS_RUN;
	wire [NCH-1:0] run_d = wr_run ? bus.wdata[NCH-1:0] : run_q;
	wire [NCH-1:0] run_rise = run_q & ~run_prev_q;

	// channel 0 counter and comparators
	wire ch0_tick = tick_i[0] && run_q[0];
	wire match_a = ch0_tick && cnt_q == compare_a_register_q;
	// a zero period register means a full-range count, ended only by overflow
	wire match_p = ch0_tick && cnt_q == period_compare_register_q && period_compare_register_q != '0;
	wire ovf = ch0_tick && &cnt_q;
	wire [NCH-1:0] src_now;
	wire [NCH-1:0] rise_v = src_now & ~src_prev_q;
	wire [NCH-1:0] fall_v = ~src_now & src_prev_q;
	wire ch0_cap_mode = ctrl_q[0].mode_sel == ptmc_pkg::PTMC_CAP;
	wire cap_hit0 = ch0_cap_mode && run_q[0] && edge_hit(ctrl_q[0].pin_func, rise_v[0], fall_v[0]);
	wire cap_to_b = cap_hit0 && clrcond_q != 2'h0 && rise_v[0];
	wire cap_to_a = cap_hit0 && !cap_to_b;
	wire edge_clr = ch0_cap_mode && run_q[0] &&
		((clrcond_q[0] && rise_v[0]) || (clrcond_q[1] && fall_v[0]));
	wire sel_a = ctrl_q[0].counter_clear_sel &&
		(ctrl_q[0].mode_sel == ptmc_pkg::PTMC_CMP || ctrl_q[0].mode_sel == ptmc_pkg::PTMC_TMR);
	wire cnt_clr = sel_a ? match_a : (match_p || (ovf && period_compare_register_q == '0)) || edge_clr;
	logic [W-1:0] cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (run_d[0] && !run_q[0])
			cnt_d = '0;
		else if (ch0_tick)
			cnt_d = cnt_clr ? '0 : W'(cnt_q + 1'b1);
		else if (edge_clr)
			cnt_d = '0;
	end

	// register file writes
	function automatic logic [W-1:0] byte_wr(input logic [W-1:0] v, input logic hi, input logic [7:0] d);
		byte_wr = hi ? {d, v[7:0]} : {v[W-1:8], d};
	endfunction
	wire wr_a = bus.wr && (bus.addr == ptmc_pkg::OFS_COMPARE_A_REGISTER_LO || bus.addr == ptmc_pkg::OFS_COMPARE_A_REGISTER_HI);
	wire wr_p = bus.wr && (bus.addr == ptmc_pkg::OFS_PERIOD_COMPARE_REGISTER_LO || bus.addr == ptmc_pkg::OFS_PERIOD_COMPARE_REGISTER_HI);
	wire wr_b = bus.wr && (bus.addr == ptmc_pkg::OFS_CAPTURE_B_REGISTER_LO || bus.addr == ptmc_pkg::OFS_CAPTURE_B_REGISTER_HI);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			run_q <= '0;
			run_prev_q <= '0;
			clrcond_q <= 2'h0;
			cnt_q <= '0;
			compare_a_register_q <= '0;
			period_compare_register_q <= '0;
			capture_b_register_q <= '0;
		end else begin
			run_q <= run_d;
			run_prev_q <= run_q;
			if (bus.wr && bus.addr == ptmc_pkg::OFS_CLRCOND)
				clrcond_q <= bus.wdata[2:1];
			cnt_q <= cnt_d;
			// capture takes priority over a software write
			if (cap_to_a)
				compare_a_register_q <= cnt_q;
			else if (wr_a)
				compare_a_register_q <= byte_wr(compare_a_register_q, bus.addr[0], bus.wdata);
			if (cap_to_b)
				capture_b_register_q <= cnt_q;
			else if (wr_b)
				capture_b_register_q <= byte_wr(capture_b_register_q, bus.addr[0], bus.wdata);
			if (wr_p)
				period_compare_register_q <= byte_wr(period_compare_register_q, bus.addr[0], bus.wdata);
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			ptmc_pkg::ptmc_ctrl_s c;
			assign c = ctrl_q[g];
			// channel 0 match drives its pin; others use their tick as a match stand-in
			wire m = (g == 0) ? match_a : (tick_i[g] && run_q[g]);
			wire pmatch = (g == 0) ? match_p : (tick_i[g] && run_q[g]);
			assign src_now[g] = !c.capture_source_sel ? capture_input_pin_i[g] :
				noise_filter_input_select_i[g] ? noise_filter_out_i[g] : filt_q[g];
			logic pin_d;
			always_comb begin
				pin_d = pin_q[g];
				unique case (c.mode_sel)
					ptmc_pkg::PTMC_CMP: begin
						if (run_rise[g])
							pin_d = c.output_level_bit;
						else if (m) begin
							unique case (c.pin_func)
								2'h0: pin_d = pin_q[g];
								2'h1: pin_d = 1'b0;
								2'h2: pin_d = 1'b1;
								2'h3: pin_d = ~pin_q[g];
							endcase
						end
					end
					ptmc_pkg::PTMC_PWM: begin
						unique case (c.pin_func)
							2'h0: pin_d = ~c.output_level_bit;
							2'h1: pin_d = c.output_level_bit;
							2'h2: pin_d = run_q[g] && !m ? (pmatch ? c.output_level_bit : pin_q[g])
								: (m ? ~c.output_level_bit : pin_q[g]);
							2'h3: pin_d = run_rise[g] ? c.output_level_bit :
								(m || pulse_done_q[g]) ? ~c.output_level_bit : pin_q[g];
						endcase
					end
					// timer and capture modes hold, pin function ignored
					default: pin_d = pin_q[g];
				endcase
			end
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					pin_q[g] <= 1'b0;
					pulse_done_q[g] <= 1'b0;
					src_prev_q[g] <= 1'b0;
					filt_cnt_q[g] <= '0;
					filt_q[g] <= 1'b0;
					timer_output_pin_o[g] <= 1'b0;
					timer_output_oe_o[g] <= 1'b0;
				end else begin
					pin_q[g] <= pin_d;
					// a match in the run-rise cycle still ends the pulse, so set wins
					pulse_done_q[g] <= m | (pulse_done_q[g] & ~run_rise[g]);
					src_prev_q[g] <= src_now[g];
					// 150 ns glitch filter on the clock pin
					if (timer_clock_input_pin_i[g] == filt_q[g])
						filt_cnt_q[g] <= '0;
					else if (filt_cnt_q[g] == 6'(ptmc_pkg::FILT_CYC - 1)) begin
						filt_q[g] <= timer_clock_input_pin_i[g];
						filt_cnt_q[g] <= '0;
					end else
						filt_cnt_q[g] <= 6'(filt_cnt_q[g] + 1'b1);
					// polarity, not applied in timer mode
					timer_output_pin_o[g] <= pin_d ^ (c.output_polarity_bit && c.mode_sel != ptmc_pkg::PTMC_TMR);
					timer_output_oe_o[g] <= c.mode_sel == ptmc_pkg::PTMC_CMP || c.mode_sel == ptmc_pkg::PTMC_PWM;
				end
			end
			always_ff @(posedge clock_i) begin
				if (rst_i)
					ctrl_q[g] <= ptmc_pkg::CTRL_RESET;
				else if (bus.wr && bus.addr == 4'(g))
					ctrl_q[g] <= bus.wdata;
			end
		end
	endgenerate

	// mode decode is the ptmc_mode_e field; capture edge for channels 1..3 via edge_hit
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (bus.addr)
			ptmc_pkg::OFS_CTRL0: rd_mux = ctrl_q[0];
			ptmc_pkg::OFS_CTRL1: rd_mux = ctrl_q[1];
			ptmc_pkg::OFS_CTRL2: rd_mux = ctrl_q[2];
			ptmc_pkg::OFS_CTRL3: rd_mux = ctrl_q[3];
			ptmc_pkg::OFS_RUN: rd_mux = 8'(run_q);
			ptmc_pkg::OFS_CLRCOND: rd_mux = {5'h00, clrcond_q, 1'b0};
			ptmc_pkg::OFS_CNT_LO: rd_mux = cnt_q[7:0];
			ptmc_pkg::OFS_CNT_HI: rd_mux = cnt_q[15:8];
			ptmc_pkg::OFS_COMPARE_A_REGISTER_LO: rd_mux = compare_a_register_q[7:0];
			ptmc_pkg::OFS_COMPARE_A_REGISTER_HI: rd_mux = compare_a_register_q[15:8];
			ptmc_pkg::OFS_PERIOD_COMPARE_REGISTER_LO: rd_mux = period_compare_register_q[7:0];
			ptmc_pkg::OFS_PERIOD_COMPARE_REGISTER_HI: rd_mux = period_compare_register_q[15:8];
			ptmc_pkg::OFS_CAPTURE_B_REGISTER_LO: rd_mux = capture_b_register_q[7:0];
			ptmc_pkg::OFS_CAPTURE_B_REGISTER_HI: rd_mux = capture_b_register_q[15:8];
			ptmc_pkg::OFS_STATUS: rd_mux = 8'(pin_q);
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clock_i) begin
		if (rst_i)
			rdata_q <= 8'h00;
		else
			rdata_q <= bus.rd ? rd_mux : 8'h00;
	end
	assign rdata_o = rdata_q;

	wire [NCH-1:0] cap_ev;
	generate
		for (g = 1; g < NCH; g++) begin : g_cap
			assign cap_ev[g] = ctrl_q[g].mode_sel == ptmc_pkg::PTMC_CAP &&
				edge_hit(ctrl_q[g].pin_func, rise_v[g], fall_v[g]);
		end
	endgenerate
	assign cap_ev[0] = cap_hit0;

	property p_run_clear;
		@(posedge clock_i) disable iff (rst_i) (run_q[0] && !run_prev_q[0]) |-> cnt_q == '0;
	endproperty
	a_run_clear: assert property (p_run_clear) else $error("counter not cleared on run rise");
	property p_cap_a;
		@(posedge clock_i) disable iff (rst_i) (cap_hit0 && clrcond_q == 2'h0) |=> compare_a_register_q == $past(cnt_q);
	endproperty
	a_cap_a: assert property (p_cap_a) else $error("capture not in compare A");
	property p_cap_b;
		@(posedge clock_i) disable iff (rst_i) cap_to_b |=> capture_b_register_q == $past(cnt_q);
	endproperty
	a_cap_b: assert property (p_cap_b) else $error("rising capture not in B");
	property p_cmp_low;
		@(posedge clock_i) disable iff (rst_i)
			(ctrl_q[0].mode_sel == ptmc_pkg::PTMC_CMP && ctrl_q[0].pin_func == 2'h1 && match_a && !run_rise[0]) |=> !pin_q[0];
	endproperty
	a_cmp_low: assert property (p_cmp_low) else $error("pin not low after match");
	property p_init;
		@(posedge clock_i) disable iff (rst_i)
			(ctrl_q[0].mode_sel == ptmc_pkg::PTMC_CMP && run_rise[0]) |=> pin_q[0] == $past(ctrl_q[0].output_level_bit);
	endproperty
	a_init: assert property (p_init) else $error("pin not at initial level");
	property p_pol;
		@(posedge clock_i) disable iff (rst_i)
			(ctrl_q[0].mode_sel == ptmc_pkg::PTMC_PWM && ctrl_q[0].output_polarity_bit) |=> timer_output_pin_o[0] == !pin_q[0];
	endproperty
	a_pol: assert property (p_pol) else $error("polarity not applied");
	property p_force;
		@(posedge clock_i) disable iff (rst_i)
			(ctrl_q[1].mode_sel == ptmc_pkg::PTMC_PWM && ctrl_q[1].pin_func == 2'h1) ##1 $stable(ctrl_q[1]) |-> pin_q[1] == ctrl_q[1].output_level_bit;
	endproperty
	a_force: assert property (p_force) else $error("forced active level wrong");
	property p_clr_a;
		@(posedge clock_i) disable iff (rst_i) (sel_a && match_a && !(run_d[0] && !run_q[0])) |=> cnt_q == '0;
	endproperty
	a_clr_a: assert property (p_clr_a) else $error("no clear on match A");
	property p_run_hold;
		@(posedge clock_i) disable iff (rst_i)
			(!run_q[0] && !run_d[0]) |=> $stable(cnt_q);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("counter moved while stopped");
	property p_clr_p;
		@(posedge clock_i) disable iff (rst_i)
			(!sel_a && match_p) |=> cnt_q == '0;
	endproperty
	a_clr_p: assert property (p_clr_p) else $error("no clear on match P");
	property p_edge_clr;
		@(posedge clock_i) disable iff (rst_i)
			(ch0_cap_mode && run_q[0] && clrcond_q[0] && rise_v[0]) |=> cnt_q == '0;
	endproperty
	a_edge_clr: assert property (p_edge_clr) else $error("no clear on rising capture edge");
	property p_cap_dis;
		@(posedge clock_i) disable iff (rst_i)
			(ctrl_q[1].mode_sel == ptmc_pkg::PTMC_CAP && ctrl_q[1].pin_func == 2'h3) |-> !cap_ev[1];
	endproperty
	a_cap_dis: assert property (p_cap_dis) else $error("capture while disabled");
	property p_oe_cmp;
		@(posedge clock_i) disable iff (rst_i)
			ctrl_q[0].mode_sel == ptmc_pkg::PTMC_CMP |=> timer_output_oe_o[0];
	endproperty
	a_oe_cmp: assert property (p_oe_cmp) else $error("pin not driven in compare mode");
	property p_tmr_oe;
		@(posedge clock_i) disable iff (rst_i)
			ctrl_q[3].mode_sel == ptmc_pkg::PTMC_TMR |=> !timer_output_oe_o[3];
	endproperty
	a_tmr_oe: assert property (p_tmr_oe) else $error("pin driven in timer mode");
	property p_tmr_pol;
		@(posedge clock_i) disable iff (rst_i)
			ctrl_q[3].mode_sel == ptmc_pkg::PTMC_TMR |=> timer_output_pin_o[3] == pin_q[3];
	endproperty
	a_tmr_pol: assert property (p_tmr_pol) else $error("polarity applied in timer mode");
	property p_pulse;
		@(posedge clock_i) disable iff (rst_i)
			(ctrl_q[2].mode_sel == ptmc_pkg::PTMC_PWM && ctrl_q[2].pin_func == 2'h3 && run_rise[2])
				|=> pin_q[2] == $past(ctrl_q[2].output_level_bit);
	endproperty
	a_pulse: assert property (p_pulse) else $error("single pulse start level wrong");
	c_cap: cover property (@(posedge clock_i) disable iff (rst_i) cap_ev[1]);
	c_toggle: cover property (@(posedge clock_i) disable iff (rst_i) match_a && ctrl_q[0].pin_func == 2'h3);
	c_capb: cover property (@(posedge clock_i) disable iff (rst_i) cap_to_b);
	c_edge_clr: cover property (@(posedge clock_i) disable iff (rst_i) edge_clr);
	c_clr_a: cover property (@(posedge clock_i) disable iff (rst_i) sel_a && match_a);
endmodule

// [dv/ptmc_pin_model.sv]
// Purpose: external pins around the timer: tick source, capture pins, filter side
// Assumes: bench asks for ticks and capture levels one cycle ahead
// Notes: clock pin and filter select are constant, the rest registered, so pins change only just after a clock edge
`timescale 1ns/100ps
module ptmc_pin_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// requests from the bench
	input wire logic [3:0] tick_req_i,
	input wire logic [3:0] cap_req_i,
	// pins toward the timer
	output logic [3:0] tick_o,
	output logic [3:0] cap_pin_o,
	output logic [3:0] clk_pin_o,
	output logic [3:0] nf_out_o,
	output logic [3:0] nf_sel_o
);
	assign nf_sel_o = 4'h0;
	// clock pin stands still, no external count clock in use
	assign clk_pin_o = 4'h0;
	always_ff @(posedge clock_i) begin
		tick_o <= rst_i ? 4'h0 : tick_req_i;
		cap_pin_o <= rst_i ? 4'h0 : cap_req_i;
		// unused filter output keeps moving so a stray select shows up
		nf_out_o <= rst_i ? 4'h5 : ~nf_out_o;
	end
endmodule

// [dv/periodic_timer_mode_control_tb_top.sv]
// Purpose: self-checking bench of the timer mode control block
// Assumes: ticks on channels 1-3 act as compare A matches
// Notes: software stops a channel before every mode or pin-function change
`timescale 1ns/100ps
module periodic_timer_mode_control_tb_top;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o;
	logic [3:0] tick_req = 4'h0;
	logic [3:0] cap_req = 4'h0;
	logic [3:0] tick, cap_pin, clk_pin, nf_out, nf_sel, pin, oe;
	int num_errors = 0;
	int checked = 0;
	int cnt;
	int cap_q[$];
	logic [7:0] rv;
	always #2.5 clock_i = ~clock_i;
	ptmc_pin_model u_pins (.clock_i(clock_i), .rst_i(rst_i), .tick_req_i(tick_req), .cap_req_i(cap_req),
		.tick_o(tick), .cap_pin_o(cap_pin), .clk_pin_o(clk_pin), .nf_out_o(nf_out), .nf_sel_o(nf_sel));
	ptmc_top DUT (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .tick_i(tick), .capture_input_pin_i(cap_pin),
		.timer_clock_input_pin_i(clk_pin), .noise_filter_out_i(nf_out),
		.noise_filter_input_select_i(nf_sel), .timer_output_pin_o(pin), .timer_output_oe_o(oe));
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic ticks(input logic [3:0] ch, input int n);
		repeat (n) begin
			@(posedge clock_i);
			tick_req <= ch;
		end
		@(posedge clock_i);
		tick_req <= 4'h0;
		repeat (4) @(posedge clock_i);
		if (ch[0]) cnt += n;
	endtask
	task automatic cap(input logic lv);
		@(posedge clock_i);
		cap_req <= {3'h0, lv};
		repeat (4) @(posedge clock_i);
		cap_q.push_back(cnt);
	endtask
	// model of the compare-mode pin, polarity applied last
	function automatic logic exp_pin(int pf, int oc, int pol, int m);
		int lv;
		lv = oc;
		if (m > 0) begin
			case (pf)
				1: lv = 0;
				2: lv = 1;
				3: lv = 1 - oc;
				default: lv = oc;
			endcase
		end
		return logic'((lv ^ pol) & 1);
	endfunction
	task automatic start(input logic [3:0] ofs, input logic [7:0] c, input logic [3:0] run);
		wr(ptmc_pkg::OFS_RUN, 8'h00);
		wr(ofs, c);
		wr(ptmc_pkg::OFS_RUN, {4'h0, run});
		repeat (3) @(posedge clock_i);
	endtask
	task automatic results();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		results();
	end
	initial begin
		void'($urandom(33));
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(4'(i), rv);
			chk("ctrl reset", rv, ptmc_pkg::CTRL_RESET);
		end
		rd(4'hf, rv);
		chk("unmapped", rv, 8'h00);
		for (int i = 1; i < 4; i++) begin
			logic [7:0] r;
			r = 8'($urandom());
			wr(4'(i), r);
			rd(4'(i), rv);
			chk("ctrl readback", rv, r);
		end
		for (int k = 0; k < 16; k++) begin
			start(ptmc_pkg::OFS_CTRL1, {2'h0, 2'(k >> 2), 1'(k >> 1), 1'(k), 2'h1}, 4'h2);
			chk("cmp initial", {7'h0, pin[1]}, {7'h0, exp_pin(k >> 2, (k >> 1) & 1, k & 1, 0)});
			chk("cmp oe", {7'h0, oe[1]}, 8'h01);
			ticks(4'h2, 1);
			chk("cmp match", {7'h0, pin[1]}, {7'h0, exp_pin(k >> 2, (k >> 1) & 1, k & 1, 1)});
			wr(ptmc_pkg::OFS_RUN, 8'h00);
			wr(ptmc_pkg::OFS_RUN, 8'h02);
			repeat (3) @(posedge clock_i);
			chk("cmp rerun", {7'h0, pin[1]}, {7'h0, exp_pin(k >> 2, (k >> 1) & 1, k & 1, 0)});
		end
		for (int k = 0; k < 8; k++) begin
			start(ptmc_pkg::OFS_CTRL2, {2'h2, 1'b0, 1'(k >> 2), 1'(k >> 1), 1'(k), 2'h1}, 4'h4);
			chk("pwm forced", {7'h0, pin[2]}, {7'h0, 1'((((k >> 2) & 1) ? (k >> 1) : ~(k >> 1)) ^ k)});
		end
		start(ptmc_pkg::OFS_CTRL3, 8'hff, 4'h8);
		chk("timer oe", {7'h0, oe[3]}, 8'h00);
		wr(ptmc_pkg::OFS_PERIOD_COMPARE_REGISTER_LO, 8'hff);
		start(ptmc_pkg::OFS_CTRL0, 8'h40, 4'h1);
		cnt = 0;
		ticks(4'h1, 5);
		cap(1'b1);
		rd(ptmc_pkg::OFS_COMPARE_A_REGISTER_LO, rv);
		chk("capture a", rv, 8'(cap_q.pop_front()));
		wr(ptmc_pkg::OFS_CLRCOND, 8'h02);
		start(ptmc_pkg::OFS_CTRL0, 8'h60, 4'h1);
		cnt = 0;
		rd(ptmc_pkg::OFS_CNT_LO, rv);
		chk("run clears", rv, 8'h00);
		ticks(4'h1, 3);
		cap(1'b0);
		ticks(4'h1, 2);
		cap(1'b1);
		rd(ptmc_pkg::OFS_COMPARE_A_REGISTER_LO, rv);
		chk("fall to a", rv, 8'(cap_q.pop_front()));
		rd(ptmc_pkg::OFS_CAPTURE_B_REGISTER_LO, rv);
		chk("rise to b", rv, 8'(cap_q.pop_front()));
		rd(ptmc_pkg::OFS_CNT_LO, rv);
		chk("edge clear", rv, 8'h00);
		// channel 0 compare mode: initial high, low on match A, clear on match A
		wr(ptmc_pkg::OFS_COMPARE_A_REGISTER_LO, 8'h03);
		wr(ptmc_pkg::OFS_COMPARE_A_REGISTER_HI, 8'h00);
		start(ptmc_pkg::OFS_CTRL0, 8'h19, 4'h1);
		cnt = 0;
		chk("cmp0 initial", {7'h0, pin[0]}, {7'h0, exp_pin(1, 1, 0, 0)});
		chk("cmp0 oe", {7'h0, oe[0]}, 8'h01);
		ticks(4'h1, 4);
		chk("cmp0 low", {7'h0, pin[0]}, {7'h0, exp_pin(1, 1, 0, 1)});
		rd(ptmc_pkg::OFS_CNT_LO, rv);
		chk("clear on a", rv, 8'(cnt % (3 + 1)));
		results();
	end
endmodule
